/* src/self_test_control.sv */
`timescale 1ns/100ps
`include "stc_consts.svh"

module self_test_control #(
  parameter int NPORTS = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic self_test_pin,
  input wire logic [1:0] gpio_in,
  input wire logic [NPORTS-1:0] rx_bit,
  input wire logic [NPORTS-1:0] rx_bit_valid,
  input wire logic [NPORTS-1:0] rx_lock,
  input wire logic line_monitor_in,
  input wire logic pattern_gen_en,
  output logic bc_wr_req,
  output stc_pkg::byte_t bc_wr_addr,
  output stc_pkg::byte_t bc_wr_data,
  input wire logic bc_wr_ack,
  input wire logic remote_self_test_active,
  output logic [NPORTS-1:0] lock_out,
  output logic [NPORTS-1:0] pass_out,
  output logic line_monitor_output,
  output logic outputs_enable,
  output logic csi_force_lp11,
  output logic self_test_active,
  output logic irq
);
  import stc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] a, input byte_t idx);
    reg_hit = (a == {2'b00, idx, 2'b00});
  endfunction

  function automatic byte_t sat_inc(input byte_t v);
    sat_inc = (v >= `STC_TALLY_MAX) ? `STC_TALLY_MAX : v + 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_s_q, pin_s_d;
  logic [1:0] gp1_q, gp1_d, gp2_q, gp2_d, gp3_q, gp3_d;
  logic pin_f_q, pin_f_d;
  logic [1:0] gp_f_q, gp_f_d;

  // filtered level changes once stages two and three agree
  always_comb begin
    pin_s_d = {pin_s_q[1:0], self_test_pin};
    gp1_d = gpio_in;
    gp2_d = gp1_q;
    gp3_d = gp2_q;
    pin_f_d = (pin_s_q[1] == pin_s_q[2]) ? pin_s_q[2] : pin_f_q;
    gp_f_d = gp_f_q;
    for (int i = 0; i < 2; i++) begin
      if (gp2_q[i] == gp3_q[i]) begin
        gp_f_d[i] = gp3_q[i];
      end
    end
  end

  // synchroniser registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s_q <= 3'h0;
      gp1_q <= 2'h0;
      gp2_q <= 2'h0;
      gp3_q <= 2'h0;
      pin_f_q <= 1'b0;
      gp_f_q <= 2'h0;
    end else begin
      pin_s_q <= pin_s_d;
      gp1_q <= gp1_d;
      gp2_q <= gp2_d;
      gp3_q <= gp3_d;
      pin_f_q <= pin_f_d;
      gp_f_q <= gp_f_d;
    end
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  byte_t ctl_q, ctl_d;
  logic [7:0] port_sel_q, port_sel_d;
  logic [`STC_IRQ_W-1:0] istat_q, istat_d, imask_q, imask_d;
  logic [`STC_IRQ_W-1:0] ev;
  logic [31:0] rdata_q, rdata_d;
  logic wr_en, rd_setup, mapped;
  byte_t tally_sel;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = reg_hit(paddr, `STC_IDX_TALLY) ||
                  reg_hit(paddr, `STC_IDX_CTL) ||
                  reg_hit(paddr, `STC_IDX_RSTAT) ||
                  reg_hit(paddr, `STC_IDX_PORTSEL) ||
                  reg_hit(paddr, `STC_IDX_ISTAT) ||
                  reg_hit(paddr, `STC_IDX_IMASK);
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // test sequencer
  // ----------------------------------------------------------------
  test_state_t st_q, st_d;
  logic [1:0] clk_sel_q, clk_sel_d;
  logic test_req;
  logic running;

  assign test_req = pin_f_q || ctl_q[`STC_CTL_EN];
  assign running = (st_q == ST_RUN);

  // next state and remote programming
  always_comb begin
    st_d = st_q;
    clk_sel_d = clk_sel_q;
    case (st_q)
      ST_IDLE: begin
        if (test_req) begin
          st_d = ST_ARM;
          if (pin_f_q) begin
            clk_sel_d = gp_f_q;
          end else begin
            clk_sel_d = ctl_q[`STC_CTL_CLK_HI:`STC_CTL_CLK_LO];
          end
        end
      end
      ST_ARM: begin
        if (bc_wr_ack) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!test_req) begin
          st_d = ST_DISARM;
        end
      end
      ST_DISARM: begin
        if (bc_wr_ack) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      clk_sel_q <= 2'h0;
    end else begin
      st_q <= st_d;
      clk_sel_q <= clk_sel_d;
    end
  end

  // back-channel write held until acknowledged
  always_comb begin
    bc_wr_req = (st_q == ST_ARM) || (st_q == ST_DISARM);
    bc_wr_addr = `STC_SER_REG;
    bc_wr_data = `STC_TALLY_ZERO;
    if (st_q == ST_ARM) begin
      bc_wr_data[`STC_CTL_CLK_HI:`STC_CTL_CLK_LO] = clk_sel_q;
      bc_wr_data[`STC_SER_EN] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // per-port checking and tallies
  // ----------------------------------------------------------------
  logic [NPORTS-1:0] err;
  byte_t tally_q [NPORTS];
  byte_t tally_d [NPORTS];
  logic [NPORTS-1:0] seen_q, seen_d, lost_q, lost_d;
  logic start_ev;

  assign start_ev = (st_q == ST_IDLE) && test_req;

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    prbs_checker u_chk (
      .mclk(mclk),
      .rst(rst),
      .check_en(running && rx_lock[p]),
      .bit_in(rx_bit[p]),
      .bit_valid(rx_bit_valid[p]),
      .err_pulse(err[p])
    );
  end

  // count errors, remember lock history
  always_comb begin
    seen_d = seen_q;
    lost_d = lost_q;
    for (int p = 0; p < NPORTS; p++) begin
      tally_d[p] = tally_q[p];
      if (start_ev) begin
        tally_d[p] = `STC_TALLY_ZERO;
        seen_d[p] = 1'b0;
        lost_d[p] = 1'b0;
      end else if (running) begin
        if (rx_lock[p]) begin
          seen_d[p] = 1'b1;
        end else if (seen_q[p]) begin
          lost_d[p] = 1'b1;
        end
        if (err[p] && rx_lock[p]) begin
          tally_d[p] = sat_inc(tally_q[p]);
        end
      end
    end
  end

  // tally registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_q <= '0;
      lost_q <= '0;
      for (int p = 0; p < NPORTS; p++) begin
        tally_q[p] <= `STC_TALLY_ZERO;
      end
    end else begin
      seen_q <= seen_d;
      lost_q <= lost_d;
      for (int p = 0; p < NPORTS; p++) begin
        tally_q[p] <= tally_d[p];
      end
    end
  end

  // selected port tally, failure code overrides the count
  always_comb begin
    tally_sel = `STC_TALLY_ZERO;
    for (int p = 0; p < NPORTS; p++) begin
      if (port_sel_q == 8'(p)) begin
        tally_sel = (lost_q[p] || !seen_q[p]) ? `STC_TALLY_FAIL
                                              : tally_q[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers, interrupts and read data
  // ----------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[`STC_IRQ_START] = start_ev;
    ev[`STC_IRQ_DONE] = running && !test_req;
    ev[`STC_IRQ_ERR] = running && |(err & rx_lock);
    ev[`STC_IRQ_LOCK] = running && |(seen_q & ~rx_lock);
    ctl_d = ctl_q;
    port_sel_d = port_sel_q;
    imask_d = imask_q;
    istat_d = istat_q;
    if (wr_en && reg_hit(paddr, `STC_IDX_CTL)) begin
      ctl_d = pwdata[7:0];
    end
    if (wr_en && reg_hit(paddr, `STC_IDX_PORTSEL)) begin
      port_sel_d = pwdata[7:0];
    end
    if (wr_en && reg_hit(paddr, `STC_IDX_IMASK)) begin
      imask_d = pwdata[`STC_IRQ_W-1:0];
    end
    if (wr_en && reg_hit(paddr, `STC_IDX_ISTAT)) begin
      istat_d = istat_q & ~pwdata[`STC_IRQ_W-1:0];
    end
    istat_d = istat_d | ev; // set wins over clear
    rdata_d = rdata_q;
    if (rd_setup) begin
      rdata_d = 32'h0;
      if (reg_hit(paddr, `STC_IDX_TALLY)) begin
        rdata_d[7:0] = tally_sel;
      end
      if (reg_hit(paddr, `STC_IDX_CTL)) begin
        rdata_d[7:0] = ctl_q;
      end
      if (reg_hit(paddr, `STC_IDX_RSTAT)) begin
        rdata_d[`STC_RSTAT_RACT] = remote_self_test_active;
        rdata_d[`STC_RSTAT_LACT] = (st_q != ST_IDLE);
      end
      if (reg_hit(paddr, `STC_IDX_PORTSEL)) begin
        rdata_d[7:0] = port_sel_q;
      end
      if (reg_hit(paddr, `STC_IDX_ISTAT)) begin
        rdata_d[`STC_IRQ_W-1:0] = istat_q;
      end
      if (reg_hit(paddr, `STC_IDX_IMASK)) begin
        rdata_d[`STC_IRQ_W-1:0] = imask_q;
      end
    end
  end

  // register file
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_q <= `STC_CTL_RST;
      port_sel_q <= 8'h00;
      imask_q <= '0;
      istat_q <= '0;
      rdata_q <= 32'h0;
    end else begin
      ctl_q <= ctl_d;
      port_sel_q <= port_sel_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign irq = |(istat_q & imask_q);

  // ----------------------------------------------------------------
  // device outputs
  // ----------------------------------------------------------------
  logic [NPORTS-1:0] lock_q, pass_q;
  logic lmon_q;

  // status outputs run in every mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lock_q <= '0;
      pass_q <= '0;
      lmon_q <= 1'b0;
    end else begin
      lock_q <= rx_lock;
      pass_q <= rx_lock & ~err;
      lmon_q <= line_monitor_in;
    end
  end

  assign lock_out = lock_q;
  assign pass_out = pass_q;
  assign line_monitor_output = lmon_q;
  assign self_test_active = (st_q != ST_IDLE);

  // only the 10 setting lets outputs run during the test
  assign outputs_enable = !self_test_active ||
    (ctl_q[`STC_CTL_GATE_HI:`STC_CTL_GATE_LO] == `STC_GATE_ON);
  assign csi_force_lp11 = self_test_active && outputs_enable &&
    !pattern_gen_en;
endmodule

/* common/stc_consts.svh */
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define STC_IDX_TALLY 8'h57
`define STC_IDX_CTL 8'hb3
`define STC_IDX_RSTAT 8'hd0
`define STC_IDX_PORTSEL 8'h4c
`define STC_IDX_ISTAT 8'he0
`define STC_IDX_IMASK 8'he1

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define STC_CTL_RST 8'h00
`define STC_CTL_EN 0
`define STC_CTL_CLK_HI 2
`define STC_CTL_CLK_LO 1
`define STC_CTL_GATE_HI 7
`define STC_CTL_GATE_LO 6
`define STC_GATE_OFF 2'b00
`define STC_GATE_ON 2'b10

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define STC_RSTAT_LACT 0
`define STC_RSTAT_RACT 5

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define STC_IRQ_W 4
`define STC_IRQ_START 0
`define STC_IRQ_DONE 1
`define STC_IRQ_ERR 2
`define STC_IRQ_LOCK 3

// ----------------------------------------------------------------
// remote serializer programming
// ----------------------------------------------------------------
`define STC_SER_REG 8'h14
`define STC_SER_EN 0

// ----------------------------------------------------------------
// error tally values
// ----------------------------------------------------------------
`define STC_TALLY_FAIL 8'hff
`define STC_TALLY_MAX 8'hfe
`define STC_TALLY_ZERO 8'h00

// ----------------------------------------------------------------
// pseudo-random sequence (x^7 + x^6 + 1)
// ----------------------------------------------------------------
`define STC_PRBS_LEN 7
`define STC_PRBS_TAP_A 6
`define STC_PRBS_TAP_B 5

`endif

/* common/stc_pkg.sv */
package stc_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARM = 4'b0010,
    ST_RUN = 4'b0100,
    ST_DISARM = 4'b1000
  } test_state_t;
endpackage

/* src/prbs_checker.sv */
`timescale 1ns/100ps
`include "stc_consts.svh"

module prbs_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic check_en,
  input wire logic bit_in,
  input wire logic bit_valid,
  output logic err_pulse
);
  import stc_pkg::*;

  logic [`STC_PRBS_LEN-1:0] shift_q, shift_d;
  logic [2:0] fill_q, fill_d;
  logic err_q, err_d;
  logic expected;
  logic full;

  // self-synchronising compare: the history seeds the prediction
  always_comb begin
    expected = shift_q[`STC_PRBS_TAP_A] ^ shift_q[`STC_PRBS_TAP_B];
    full = (fill_q == 3'(`STC_PRBS_LEN));
    shift_d = shift_q;
    fill_d = fill_q;
    err_d = 1'b0;
    if (!check_en) begin
      fill_d = 3'h0;
    end else if (bit_valid) begin
      shift_d = {shift_q[`STC_PRBS_LEN-2:0], bit_in};
      if (!full) begin
        fill_d = fill_q + 3'h1;
      end
      err_d = full && (bit_in != expected);
    end
  end

  // history and error registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      fill_q <= 3'h0;
      err_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      fill_q <= fill_d;
      err_q <= err_d;
    end
  end

  assign err_pulse = err_q;
endmodule

/* tb/stc_asserts.sv */
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_asserts #(
  parameter int NPORTS = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic self_test_pin,
  input wire logic [NPORTS-1:0] rx_lock,
  input wire logic line_monitor_in,
  input wire logic pattern_gen_en,
  input wire logic bc_wr_req,
  input wire stc_pkg::byte_t bc_wr_addr,
  input wire stc_pkg::byte_t bc_wr_data,
  input wire logic bc_wr_ack,
  input wire logic [NPORTS-1:0] pass_out,
  input wire logic line_monitor_output,
  input wire logic outputs_enable,
  input wire logic csi_force_lp11,
  input wire logic self_test_active
);
  import stc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // back-channel setup steps
  // ----------------------------------------------------------------
  sequence start_s; $rose(self_test_active); endsequence
  sequence arm_s; bc_wr_req && bc_wr_data[`STC_SER_EN]; endsequence
  sequence wr_done_s; bc_wr_req && bc_wr_ack; endsequence
  arm_start_a: assert property (start_s |-> arm_s)
    else $error("no setup write at test start");
  bc_hold_a: assert property (bc_wr_req && !bc_wr_ack |=>
    bc_wr_req && $stable(bc_wr_data)) else $error("write dropped early");
  bc_done_a: assert property (wr_done_s |=> !bc_wr_req)
    else $error("write held after ack");
  bc_addr_a: assert property (
    bc_wr_req |-> bc_wr_addr == `STC_SER_REG)
    else $error("write to wrong remote register");
  // ----------------------------------------------------------------
  // entry, gating and pass-through outputs
  // ----------------------------------------------------------------
  pin_start_a: assert property (self_test_pin[*8] |->
    ##[0:12] self_test_active) else $error("pin did not start test");
  gate_idle_a: assert property (
    !self_test_active |-> outputs_enable)
    else $error("outputs gated outside test");
  csi_idle_a: assert property (csi_force_lp11 ==
    (self_test_active && outputs_enable && !pattern_gen_en))
    else $error("csi idle state wrong");
  lmon_copy_a: assert property (!$past(rst) |->
    line_monitor_output == $past(line_monitor_in))
    else $error("line monitor not passed");
  pass_lock_a: assert property (
    !$past(rst) && !$past(rx_lock[0]) |-> !pass_out[0])
    else $error("pass high without lock");
endmodule

bind self_test_control stc_asserts #(.NPORTS(NPORTS)) i_chk (
  .mclk(mclk), .rst(rst), .self_test_pin(self_test_pin),
  .rx_lock(rx_lock), .line_monitor_in(line_monitor_in),
  .pattern_gen_en(pattern_gen_en), .bc_wr_req(bc_wr_req),
  .bc_wr_addr(bc_wr_addr), .bc_wr_data(bc_wr_data),
  .bc_wr_ack(bc_wr_ack), .pass_out(pass_out),
  .line_monitor_output(line_monitor_output),
  .outputs_enable(outputs_enable), .csi_force_lp11(csi_force_lp11),
  .self_test_active(self_test_active));

/* tb/remote_ser_model.sv */
`timescale 1ns/100ps
module remote_ser_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bc_wr_req,
  input wire logic [7:0] bc_wr_data,
  input wire logic [1:0] flip,
  output logic bc_wr_ack,
  output logic active,
  output logic [1:0] clk_sel,
  output logic [1:0] rx_bit,
  output logic [1:0] rx_bit_valid
);
  logic [7:0] cfg_q;
  logic [6:0] prbs_q;
  logic [1:0] wait_q;
  logic [1:0] pend_q;
  logic slow_q;
  logic tog_q;
  logic nb;
  logic step;
  assign active = cfg_q[0];
  assign clk_sel = cfg_q[2:1];
  assign nb = prbs_q[6] ^ prbs_q[5];
  // external reference runs at half the internal rate
  assign step = active && (clk_sel != 2'b00 || tog_q);
  // ----------------------------------------------------------------
  // back-channel writes: every frame accepted, prompt or slow ack
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= 8'h00;
      wait_q <= 2'h0;
      slow_q <= 1'b0;
      bc_wr_ack <= 1'b0;
    end else if (bc_wr_req && !bc_wr_ack && wait_q >= {slow_q, slow_q}) begin
      cfg_q <= bc_wr_data;
      wait_q <= 2'h0;
      slow_q <= ~slow_q;
      bc_wr_ack <= 1'b1;
    end else begin
      bc_wr_ack <= 1'b0;
      wait_q <= (bc_wr_req && !bc_wr_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
  // unbroken pseudo-random stream while active, flips on request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prbs_q <= 7'h01;
      pend_q <= 2'b00;
      tog_q <= 1'b0;
      rx_bit <= 2'b00;
      rx_bit_valid <= 2'b00;
    end else begin
      tog_q <= ~tog_q;
      pend_q <= step ? flip : (pend_q | flip);
      rx_bit_valid <= {step, step};
      rx_bit <= step ? ({nb, nb} ^ pend_q) : ~rx_bit;
      if (step) begin
        prbs_q <= {prbs_q[5:0], nb};
      end
    end
  end
endmodule

/* tb/test_self_test_control.sv */
`timescale 1ns/100ps
`include "stc_consts.svh"
module test_self_test_control;
  import stc_pkg::*;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rnd = 32'he56d1d2d;
  logic pready, pslverr, self_test_pin = 0, bc_wr_req, bc_wr_ack;
  logic line_monitor_in = 0, pattern_gen_en = 0, remote_act, irq;
  logic line_monitor_output, outputs_enable, csi_force_lp11;
  logic self_test_active;
  logic [1:0] gpio_in = 0, rx_lock = 0, flip = 0, clk_sel;
  logic [1:0] rx_bit, rx_bit_valid, lock_out, pass_out;
  byte_t bc_wr_addr, bc_wr_data;
  logic [31:0] exp_q[$];
  int err_total = 0, n_compared = 0, low_cnt = 0;
  always #12.5 mclk = ~mclk;
  self_test_control #(.NPORTS(2)) i_dut (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .self_test_pin(self_test_pin), .gpio_in(gpio_in), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .rx_lock(rx_lock),
    .line_monitor_in(line_monitor_in), .pattern_gen_en(pattern_gen_en),
    .bc_wr_req(bc_wr_req), .bc_wr_addr(bc_wr_addr),
    .bc_wr_data(bc_wr_data), .bc_wr_ack(bc_wr_ack),
    .remote_self_test_active(remote_act), .lock_out(lock_out),
    .pass_out(pass_out), .line_monitor_output(line_monitor_output),
    .outputs_enable(outputs_enable), .csi_force_lp11(csi_force_lp11),
    .self_test_active(self_test_active), .irq(irq));
  remote_ser_model i_ser (.mclk(mclk), .rst(rst), .bc_wr_req(bc_wr_req),
    .bc_wr_data(bc_wr_data), .flip(flip), .bc_wr_ack(bc_wr_ack),
    .active(remote_act), .clk_sel(clk_sel), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // random line monitor and pattern generator levels
  always @(posedge mclk) begin
    rnd <= lfsr(rnd);
    line_monitor_in <= rnd[3];
    pattern_gen_en <= rnd[7];
  end
  // cycles with pass low during a test
  always @(negedge mclk) begin
    if (self_test_active === 1'b1 && pass_out[0] === 1'b0) begin
      low_cnt++;
    end
  end
  // each finished read is compared with the oldest note
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) begin
      n_compared++;
      if (exp_q.size() == 0 || prdata !== exp_q[0]) begin
        err_total++;
        $display("CHECK FAILED prdata exp %0h got %0h", exp_q[0], prdata);
      end
      if (exp_q.size() > 0) begin
        void'(exp_q.pop_front());
      end
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] idx, logic [31:0] d);
    int n;
    n = 0;
    if (!w) begin
      exp_q.push_back(d);
    end
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pslverr", !(idx inside {`STC_IDX_TALLY, `STC_IDX_CTL,
      `STC_IDX_RSTAT, `STC_IDX_PORTSEL, `STC_IDX_ISTAT, `STC_IDX_IMASK}),
      pslverr);
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      err_total++;
      tally_and_finish();
    end
    @(posedge mclk);
  endtask
  // wait until the back channel is quiet with the asked test state
  task automatic wait_state(logic act);
    int n;
    n = 0;
    @(posedge mclk);
    while (n < 200 && (self_test_active !== act || bc_wr_req !== 1'b0)) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic flips(int k, int gap);
    repeat (k) begin
      flip <= 2'b01;
      @(posedge mclk);
      flip <= 2'b00;
      repeat (gap) @(posedge mclk);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    logic [1:0] sl;
    repeat (5) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    apb(0, `STC_IDX_CTL, {24'h0, `STC_CTL_RST});
    apb(1, 8'h01, 32'h5a);
    apb(0, 8'h01, 32'h0);
    apb(0, `STC_IDX_RSTAT, 32'h0);
    apb(1, `STC_IDX_IMASK, 32'h1 << `STC_IRQ_ERR);
    rx_lock <= 2'b11;
    // register start for each usable clock select, 11 avoided
    for (int s = 0; s < 3; s++) begin
      sl = s[1:0];
      k = int'(rnd[2:0]) + 1;
      apb(1, `STC_IDX_CTL, {24'h0, 2'b10, 3'b0, sl, 1'b1});
      wait_state(1);
      chk("clock select", sl, clk_sel);
      apb(0, `STC_IDX_RSTAT, 32'h21);
      apb(1, `STC_IDX_CTL, {24'h0, 2'b10, 3'b0, ~sl, 1'b1});
      chk("clock select held", sl, clk_sel);
      chk("outputs on", 1, outputs_enable);
      repeat (20) @(posedge mclk);
      low_cnt = 0;
      flips(k, 20);
      chk("pass low cycles", 3 * k, low_cnt);
      apb(1, `STC_IDX_PORTSEL, 32'h0);
      apb(0, `STC_IDX_TALLY, 3 * k);
      apb(1, `STC_IDX_PORTSEL, 32'h1);
      apb(0, `STC_IDX_TALLY, 32'h0);
      apb(1, `STC_IDX_CTL, 32'h0);
      wait_state(0);
      chk("remote active", 0, remote_act);
      apb(1, `STC_IDX_PORTSEL, 32'h0);
      apb(0, `STC_IDX_TALLY, 3 * k);
    end
    // data error interrupt: raised, masked, cleared
    chk("irq raised", 1, irq);
    apb(1, `STC_IDX_IMASK, 32'h0);
    chk("irq masked", 0, irq);
    apb(1, `STC_IDX_IMASK, 32'h1 << `STC_IRQ_ERR);
    apb(1, `STC_IDX_ISTAT, 32'h1 << `STC_IRQ_ERR);
    chk("irq cleared", 0, irq);
    // pin start with gated outputs, saturation and lock loss
    gpio_in <= 2'b10;
    @(posedge mclk);
    self_test_pin <= 1;
    wait_state(1);
    gpio_in <= 2'b01;
    chk("pin clock select", 2'b10, clk_sel);
    chk("outputs gated", 0, outputs_enable);
    repeat (20) @(posedge mclk);
    flips(90, 10);
    chk("pin select held", 2'b10, clk_sel);
    apb(1, `STC_IDX_PORTSEL, 32'h0);
    apb(0, `STC_IDX_TALLY, {24'h0, `STC_TALLY_MAX});
    rx_lock <= 2'b01;
    repeat (3) @(posedge mclk);
    chk("lock out", 2'b01, lock_out);
    rx_lock <= 2'b11;
    apb(1, `STC_IDX_PORTSEL, 32'h1);
    apb(0, `STC_IDX_TALLY, {24'h0, `STC_TALLY_FAIL});
    self_test_pin <= 0;
    wait_state(0);
    apb(0, `STC_IDX_RSTAT, 32'h0);
    tally_and_finish();
  end
endmodule
